// *** shared/citd_pkg.sv ***
/*
 * citd_pkg: shared types and constants of the instruction timing and decode block.
 * Assumes a 16-bit instruction word with the usual three formats.
 */
package citd_pkg;

    // timing of interrupt entry, return, resets, jumps and undefined words; counts in main clock cycles, lengths in words
    localparam logic [2:0] CYC_RET_INT = 3'h5;
    localparam logic [1:0] LEN_RET_INT = 2'h1;
    localparam logic [2:0] CYC_IRQ = 3'h6;
    localparam logic [2:0] CYC_WATCHDOG_RST = 3'h4;
    localparam logic [2:0] CYC_PIN_RST = 3'h4;
    localparam logic [2:0] CYC_JUMP = 3'h2;
    localparam logic [1:0] LEN_JUMP = 2'h1;
    localparam logic [2:0] CYC_UNDEF = 3'h1;

    // instruction word fields
    localparam int OPC_HI = 15;
    localparam int OPC_LO = 12;
    localparam int SOP_HI = 9;
    localparam int SOP_LO = 7;
    localparam int SRC_HI = 11;
    localparam int SRC_LO = 8;
    localparam int AD_POS = 7;
    localparam int BW_POS = 6;
    localparam int AS_HI = 5;
    localparam int AS_LO = 4;
    localparam int DST_HI = 3;
    localparam int DST_LO = 0;
    localparam int COND_HI = 12;
    localparam int COND_LO = 10;
    localparam int OFS_HI = 9;
    localparam logic [3:0] PC_REG = 4'h0;
    localparam logic [5:0] SINGLE_PREFIX = 6'h04;
    localparam logic [2:0] JUMP_PREFIX = 3'h1;
    localparam logic [15:0] RESET_WORD = 16'h0000;

    typedef enum logic [2:0] {
        GRP_NONE = 3'b000,
        GRP_SINGLE = 3'b001,
        GRP_JUMP = 3'b010,
        GRP_DOUBLE = 3'b011,
        GRP_IRQ = 3'b100,
        GRP_WATCHDOG = 3'b101,
        GRP_PIN = 3'b110,
        GRP_ILLEGAL = 3'b111
    } citd_group_t;

    typedef enum logic [2:0] {
        SOP_ROTATE_RIGHT_THROUGH_CARRY = 3'b000,
        SOP_BYTE_EXCHANGE = 3'b001,
        SOP_ARITH_SHIFT_RIGHT = 3'b010,
        SOP_SIGN_EXTEND_BYTE = 3'b011,
        SOP_STACK_STORE = 3'b100,
        SOP_SUBROUTINE_JUMP = 3'b101,
        SOP_RETURN_FROM_INTERRUPT = 3'b110,
        SOP_UNUSED = 3'b111
    } citd_sop_t;

    typedef enum logic [3:0] {
        DOP_MOVE_WORD = 4'h4,
        DOP_ADD = 4'h5,
        DOP_ADD_WITH_CARRY = 4'h6,
        DOP_SUBTRACT_WITH_CARRY = 4'h7,
        DOP_SUBTRACT = 4'h8,
        DOP_COMPARE_WORD = 4'h9,
        DOP_DECIMAL_ADD = 4'hA,
        DOP_BIT_TEST = 4'hB,
        DOP_BIT_CLEAR = 4'hC,
        DOP_BIT_SET = 4'hD,
        DOP_EXCLUSIVE_OR = 4'hE,
        DOP_LOGICAL_AND = 4'hF
    } citd_dop_t;

    // operand addressing classes; indexed, symbolic and absolute time alike
    typedef enum logic [2:0] {
        AM_REG = 3'b000,
        AM_IND = 3'b001,
        AM_AUTO = 3'b010,
        AM_IMM = 3'b011,
        AM_IDX = 3'b100
    } citd_amode_t;

    typedef enum logic [1:0] {
        DM_REG = 2'b00,
        DM_PC = 2'b01,
        DM_MEM = 2'b10
    } citd_dmode_t;

    typedef struct packed {
        logic [2:0] cycles;
        logic [1:0] words;
        logic undefined;
    } citd_timing_t;

    typedef struct packed {
        citd_group_t group;
        logic [3:0] op;
        logic byte_op;
        logic [2:0] cycles;
        logic [1:0] words;
        logic undefined;
    } citd_decode_t;

    // source addressing class from the As field and register number
    function automatic citd_amode_t src_mode(input logic [1:0] as_f, input logic [3:0] rn);
        citd_amode_t m;
        m = AM_REG;
        unique case (as_f)
            2'b00: m = AM_REG;
            2'b01: m = AM_IDX;
            2'b10: m = AM_IND;
            2'b11: m = (rn == PC_REG) ? AM_IMM : AM_AUTO;
        endcase
        return m;
    endfunction

    // high and low bytes exchanged
    function automatic logic [15:0] byte_swap(input logic [15:0] v);
        return {v[7:0], v[15:8]};
    endfunction

    // counter plus twice the signed word offset
    function automatic logic [15:0] jump_dest(input logic [15:0] pc, input logic [9:0] ofs);
        return pc + {{5{ofs[9]}}, ofs, 1'b0};
    endfunction

endpackage

// *** hdl/citd_mode_timing.sv ***
/*
 * citd_mode_timing: cycle count and word length of single- and double-operand
 * instructions from their addressing fields. Purely combinational.
 * Assumes the caller has already classed the word as single or double operand.
 */
`timescale 1ns/10ps
`default_nettype none

module citd_mode_timing (
    input wire logic [15:0] instr_word,
    input wire logic is_double,
    output citd_pkg::citd_timing_t timing
);

    citd_pkg::citd_amode_t am;
    citd_pkg::citd_dmode_t dm;
    citd_pkg::citd_sop_t sop;

    // addressing classes of the word
    always_comb begin
        am = citd_pkg::src_mode(instr_word[citd_pkg::AS_HI:citd_pkg::AS_LO],
            is_double ? instr_word[citd_pkg::SRC_HI:citd_pkg::SRC_LO]
                      : instr_word[citd_pkg::DST_HI:citd_pkg::DST_LO]);
        if (instr_word[citd_pkg::AD_POS]) begin
            dm = citd_pkg::DM_MEM;
        end else if (instr_word[citd_pkg::DST_HI:citd_pkg::DST_LO] == citd_pkg::PC_REG) begin
            dm = citd_pkg::DM_PC;
        end else begin
            dm = citd_pkg::DM_REG;
        end
        sop = citd_pkg::citd_sop_t'(instr_word[citd_pkg::SOP_HI:citd_pkg::SOP_LO]);
    end

    // double-operand count from format and modes only; single-operand count also from the operation
    always_comb begin
        timing = '{cycles: 3'h1, words: 2'h1, undefined: 1'b0};
        if (is_double) begin
            unique case (am)
                citd_pkg::AM_REG: begin
                    unique case (dm)
                        citd_pkg::DM_REG: timing = '{3'h1, 2'h1, 1'b0};
                        citd_pkg::DM_PC: timing = '{3'h2, 2'h1, 1'b0};
                        default: timing = '{3'h4, 2'h2, 1'b0};
                    endcase
                end
                citd_pkg::AM_IND, citd_pkg::AM_AUTO: begin
                    unique case (dm)
                        citd_pkg::DM_REG: timing = '{3'h2, 2'h1, 1'b0};
                        citd_pkg::DM_PC: timing = (am == citd_pkg::AM_AUTO) ?
                            citd_pkg::citd_timing_t'{3'h3, 2'h1, 1'b0} :
                            citd_pkg::citd_timing_t'{3'h2, 2'h1, 1'b0};
                        default: timing = '{3'h5, 2'h2, 1'b0};
                    endcase
                end
                citd_pkg::AM_IMM: begin
                    unique case (dm)
                        citd_pkg::DM_REG: timing = '{3'h2, 2'h2, 1'b0};
                        citd_pkg::DM_PC: timing = '{3'h3, 2'h2, 1'b0};
                        default: timing = '{3'h5, 2'h3, 1'b0};
                    endcase
                end
                default: begin
                    // indexed, symbolic or absolute source
                    timing = (dm == citd_pkg::DM_MEM) ? citd_pkg::citd_timing_t'{3'h6, 2'h3, 1'b0}
                        : citd_pkg::citd_timing_t'{3'h3, 2'h2, 1'b0};
                end
            endcase
        end else if (sop == citd_pkg::SOP_RETURN_FROM_INTERRUPT) begin
            timing = '{citd_pkg::CYC_RET_INT, citd_pkg::LEN_RET_INT, 1'b0};
        end else if (sop == citd_pkg::SOP_STACK_STORE) begin
            unique case (am)
                citd_pkg::AM_REG: timing = '{3'h3, 2'h1, 1'b0};
                citd_pkg::AM_IND: timing = '{3'h4, 2'h1, 1'b0};
                citd_pkg::AM_AUTO: timing = '{3'h5, 2'h1, 1'b0};
                citd_pkg::AM_IMM: timing = '{3'h4, 2'h2, 1'b0};
                default: timing = '{3'h5, 2'h2, 1'b0};
            endcase
        end else if (sop == citd_pkg::SOP_SUBROUTINE_JUMP) begin
            unique case (am)
                citd_pkg::AM_REG: timing = '{3'h4, 2'h1, 1'b0};
                citd_pkg::AM_IND: timing = '{3'h4, 2'h1, 1'b0};
                citd_pkg::AM_AUTO: timing = '{3'h5, 2'h1, 1'b0};
                default: timing = '{3'h5, 2'h2, 1'b0};
            endcase
        end else begin
            // rotate, shift, byte exchange, sign extend
            unique case (am)
                citd_pkg::AM_REG: timing = '{3'h1, 2'h1, 1'b0};
                citd_pkg::AM_IND, citd_pkg::AM_AUTO: timing = '{3'h3, 2'h1, 1'b0};
                citd_pkg::AM_IMM: timing = '{citd_pkg::CYC_UNDEF, 2'h2, 1'b1};
                default: timing = '{3'h4, 2'h2, 1'b0};
            endcase
        end
    end

endmodule // citd_mode_timing

`default_nettype wire

// *** hdl/citd_top.sv ***
/*
 * citd_top: instruction timing and opcode decode of a small 16-bit core.
 * Takes one instruction word or one interrupt/reset event, decodes it,
 * and holds busy for the documented number of main clock cycles.
 * Assumes all inputs are synchronous to clk; memory fetch is outside.
 */
`timescale 1ns/10ps
`default_nettype none

// Function
// - cycle count follows format and addressing modes; single operand also by the operation
// - interrupt entry takes six cycles; watchdog and pin resets take four
// - return from interrupt is one word and five cycles
// - register-mode single operand: one word; shifts 1, stack store 3, call 4
// - indirect single operand 3/4/4 cycles; auto-increment 3/5/5, one word
// - immediate, indexed, symbolic, absolute single operand: two words, cycles per mode
// - every jump is one word and two cycles, taken or not
// - register source double operand: 1, 2 to counter, 4 with two words to memory
// - indirect source: 2 to register, 2 or 3 to counter, 5 to memory
// - immediate source: 2 to register, 3 to counter, 5 and three words to memory
// - indexed-type source: 3 and two words to register or counter, 6 and three to memory
// - 10xx-13xx single operand by bits 9:7, byte variants at +040; 20xx-3Fxx jumps
// - top nibble 4..9 is move, add, add carry, subtract carry, subtract, compare
// - byte exchange swaps bits 15:8 with 7:0
// - unconditional jump target is counter plus twice the signed offset
module citd_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [15:0] pc_value,
    input wire logic [15:0] operand_value,
    input wire logic irq_accept,
    input wire logic watchdog_timer_reset,
    input wire logic pin_reset,
    output logic ready,
    output logic busy,
    output logic done,
    output citd_pkg::citd_decode_t decode_out,
    output logic [15:0] swap_result,
    output logic [15:0] jump_target
);

    logic rst_meta_reg;
    logic rst_sync_reg;
    logic [2:0] cnt_reg;
    logic is_double;
    logic take_instr;
    logic take_irq;
    logic start;
    citd_pkg::citd_timing_t mode_timing;
    citd_pkg::citd_decode_t decode_next;

    // reset release through two flip-flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    assign is_double = (instr_word[citd_pkg::OPC_HI:citd_pkg::OPC_LO] >= 4'h4);

    citd_mode_timing u_mode_timing (
        .instr_word(instr_word),
        .is_double(is_double),
        .timing(mode_timing)
    );

    // resets preempt anything; interrupts and instructions wait for idle
    assign take_irq = irq_accept && ready && !pin_reset && !watchdog_timer_reset;
    assign take_instr = instr_valid && ready && !irq_accept && !pin_reset
        && !watchdog_timer_reset;
    assign start = pin_reset || watchdog_timer_reset || take_irq || take_instr;

    // group, operation and timing of whatever starts this cycle
    always_comb begin
        decode_next = '{citd_pkg::GRP_NONE, 4'h0, 1'b0, 3'h0, 2'h0, 1'b0};
        if (pin_reset) begin
            decode_next = '{citd_pkg::GRP_PIN, 4'h0, 1'b0, citd_pkg::CYC_PIN_RST,
                2'h0, 1'b0};
        end else if (watchdog_timer_reset) begin
            decode_next = '{citd_pkg::GRP_WATCHDOG, 4'h0, 1'b0, citd_pkg::CYC_WATCHDOG_RST,
                2'h0, 1'b0};
        end else if (take_irq) begin
            decode_next = '{citd_pkg::GRP_IRQ, 4'h0, 1'b0, citd_pkg::CYC_IRQ,
                2'h0, 1'b0};
        end else if (is_double) begin
            decode_next = '{citd_pkg::GRP_DOUBLE,
                instr_word[citd_pkg::OPC_HI:citd_pkg::OPC_LO],
                instr_word[citd_pkg::BW_POS], mode_timing.cycles, mode_timing.words,
                mode_timing.undefined};
        end else if (instr_word[15:13] == citd_pkg::JUMP_PREFIX) begin
            decode_next = '{citd_pkg::GRP_JUMP,
                {1'b0, instr_word[citd_pkg::COND_HI:citd_pkg::COND_LO]}, 1'b0,
                citd_pkg::CYC_JUMP, citd_pkg::LEN_JUMP, 1'b0};
        end else if (instr_word[15:10] == citd_pkg::SINGLE_PREFIX
            && instr_word[citd_pkg::SOP_HI:citd_pkg::SOP_LO] != citd_pkg::SOP_UNUSED) begin
            decode_next = '{citd_pkg::GRP_SINGLE,
                {1'b0, instr_word[citd_pkg::SOP_HI:citd_pkg::SOP_LO]},
                instr_word[citd_pkg::BW_POS], mode_timing.cycles, mode_timing.words,
                mode_timing.undefined};
        end else begin
            decode_next = '{citd_pkg::GRP_ILLEGAL, 4'h0, 1'b0, citd_pkg::CYC_UNDEF,
                2'h1, 1'b1};
        end
    end

    // cycle counter: loaded on start, runs down to zero
    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            cnt_reg <= 3'h0;
        end else if (start) begin
            cnt_reg <= decode_next.cycles;
        end else if (cnt_reg != 3'h0) begin
            cnt_reg <= cnt_reg - 3'h1;
        end
    end

    // handshake flags
    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            busy <= 1'b0;
            ready <= 1'b0;
            done <= 1'b0;
        end else begin
            busy <= start || (cnt_reg > 3'h1);
            ready <= !(start || (cnt_reg > 3'h1));
            done <= !start && (cnt_reg == 3'h1);
        end
    end

    // decode result held until the next start
    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            decode_out <= '{citd_pkg::GRP_NONE, 4'h0, 1'b0, 3'h0, 2'h0, 1'b0};
        end else if (start) begin
            decode_out <= decode_next;
        end
    end

    // operand results of byte exchange and jumps
    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            swap_result <= citd_pkg::RESET_WORD;
            jump_target <= citd_pkg::RESET_WORD;
        end else if (take_instr) begin
            if (decode_next.group == citd_pkg::GRP_SINGLE
                && decode_next.op == {1'b0, citd_pkg::SOP_BYTE_EXCHANGE}) begin
                swap_result <= citd_pkg::byte_swap(operand_value);
            end
            if (decode_next.group == citd_pkg::GRP_JUMP) begin
                jump_target <= citd_pkg::jump_dest(pc_value, instr_word[citd_pkg::OFS_HI:0]);
            end
        end
    end

    // checks
    logic [3:0] busy_len_reg;
    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            busy_len_reg <= 4'h0;
        end else if (start) begin
            busy_len_reg <= 4'h0; // counts the busy cycles that follow the start
        end else if (busy) begin
            busy_len_reg <= busy_len_reg + 4'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sync_reg);

    sequence s_jump_take;
        take_instr && instr_word[15:13] == 3'h1;
    endsequence
    sequence s_quiet;
        !pin_reset && !watchdog_timer_reset;
    endsequence

    property p_busy_len;
        $fell(busy) |-> busy_len_reg == {1'b0, decode_out.cycles};
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length differs from count");

    property p_irq_six;
        take_irq ##1 s_quiet [*6] |-> busy ##1 !busy && done;
    endproperty
    a_irq_six: assert property (p_irq_six) else $error("interrupt entry not six cycles");

    property p_pin_four;
        pin_reset ##1 s_quiet [*4] |-> busy ##1 !busy;
    endproperty
    a_pin_four: assert property (p_pin_four) else $error("pin reset not four cycles");

    property p_return_from_interrupt;
        take_instr && instr_word == 16'h1300 |=> decode_out.cycles == 3'h5
            && decode_out.words == 2'h1;
    endproperty
    a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("return from interrupt timing wrong");

    property p_swap_reg;
        take_instr && instr_word[15:4] == 12'h108 |=> decode_out.cycles == 3'h1
            && decode_out.words == 2'h1;
    endproperty
    a_swap_reg: assert property (p_swap_reg) else $error("register byte exchange timing wrong");

    property p_call_ind;
        take_instr && instr_word[15:4] == 12'h12A |=> decode_out.cycles == 3'h4;
    endproperty
    a_call_ind: assert property (p_call_ind) else $error("indirect call timing wrong");

    property p_push_imm;
        take_instr && instr_word == 16'h1230 |=> decode_out.cycles == 3'h4
            && decode_out.words == 2'h2;
    endproperty
    a_push_imm: assert property (p_push_imm) else $error("immediate push timing wrong");

    property p_jump;
        s_jump_take ##1 s_quiet [*2] |-> decode_out.cycles == 3'h2 && busy ##1 !busy;
    endproperty
    a_jump: assert property (p_jump) else $error("jump not two cycles");

    property p_reg_reg;
        take_instr && instr_word[15:14] != 2'h0 && instr_word[7:4] == 4'h0
            && instr_word[3:0] != 4'h0 |=> decode_out.cycles == 3'h1;
    endproperty
    a_reg_reg: assert property (p_reg_reg) else $error("register to register not one cycle");

    property p_idx_mem;
        take_instr && instr_word[15:14] != 2'h0 && instr_word[7] && instr_word[5:4] == 2'h1
            |=> decode_out.cycles == 3'h6 && decode_out.words == 2'h3;
    endproperty
    a_idx_mem: assert property (p_idx_mem) else $error("indexed to memory timing wrong");

    property p_swap_data;
        take_instr && instr_word[15:7] == 9'h021 |=>
            swap_result == {$past(operand_value[7:0]), $past(operand_value[15:8])};
    endproperty
    a_swap_data: assert property (p_swap_data) else $error("byte exchange result wrong");

    property p_jump_dest;
        s_jump_take |=> jump_target == $past(pc_value)
            + {{5{$past(instr_word[9])}}, $past(instr_word[9:0]), 1'b0};
    endproperty
    a_jump_dest: assert property (p_jump_dest) else $error("jump target wrong");

endmodule // citd_top

`default_nettype wire

// *** verification/citd_prog_mem.sv ***
/* citd_prog_mem: behavioural program store on the far side of the decoder.
   Assumes word-aligned addresses, one write port and a fetch port. */
`timescale 1ns/10ps
`default_nettype none
module citd_prog_mem (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [15:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic [15:0] rd_addr,
    output logic [15:0] rd_data
);
    logic [15:0] mem_reg [256];
    // unwritten places read as an unassigned code, never unknown
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem_reg[i] = 16'h0000;
        end
    end
    // one program word stored per write strobe
    always @(posedge clk) begin
        if (wr_en) begin
            mem_reg[wr_addr[8:1]] <= wr_data;
        end
    end
    // fetch at the current counter value
    assign rd_data = mem_reg[rd_addr[8:1]];
endmodule // citd_prog_mem
`default_nettype wire

// *** verification/test_cpu_instruction_timing_decode.sv ***
/* test_cpu_instruction_timing_decode: self-checking bench of citd_top.
   Assumes the program store model and the shared package. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module test_cpu_instruction_timing_decode;
    typedef struct {
        citd_pkg::citd_decode_t d;
        logic [15:0] aux;
    } citd_exp_t;
    localparam logic [59:0] SGL_CYC = 60'h13314_34545_44555;
    localparam logic [59:0] DBL_CYC = 60'h124_225_235_235_336;
    localparam logic [59:0] DBL_LEN = 60'h112_112_112_223_223;
    logic clk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0, irq_accept = 1'b0;
    logic wd_rst = 1'b0, pin_rst = 1'b0, wr_en = 1'b0;
    logic [15:0] pc_value = 16'h0000, operand_value = 16'h0000;
    logic [15:0] wr_addr = 16'h0000, wr_data = 16'h0000;
    logic [15:0] instr_word, swap_result, jump_target;
    logic ready, busy, done;
    citd_pkg::citd_decode_t decode_out;
    citd_exp_t exp_q[$];
    int n_fail = 0, checked = 0, cyc = 0, busy_n = 0;
    logic [31:0] seed = 32'hE9C96CA6;

    citd_top dut_u (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr_word(instr_word), .pc_value(pc_value), .operand_value(operand_value),
        .irq_accept(irq_accept), .watchdog_timer_reset(wd_rst), .pin_reset(pin_rst),
        .ready(ready), .busy(busy), .done(done), .decode_out(decode_out),
        .swap_result(swap_result), .jump_target(jump_target));
    citd_prog_mem mem_u (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_addr(pc_value), .rd_data(instr_word));

    // clock and cycle ceiling
    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            n_fail++;
            end_of_test();
        end
    end

    // galois shift register, sixteen steps per call
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        logic [31:0] r;
        r = s;
        for (int i = 0; i < 16; i++) begin
            r = r[0] ? ((r >> 1) ^ 32'h80200003) : (r >> 1);
        end
        return r;
    endfunction

    // addressing field and register for class reg, ind, auto, imm, idx
    function automatic logic [5:0] mode_bits(input int m, input logic [3:0] r);
        logic [1:0] a;
        a = (m == 0) ? 2'h0 : ((m == 1) ? 2'h2 : ((m == 4) ? 2'h1 : 2'h3));
        return {a, (m == 3) ? 4'h0 : ((m == 2) ? (r | 4'h1) : r)};
    endfunction

    function automatic citd_exp_t mk(input citd_pkg::citd_group_t g, input logic [3:0] op,
        input logic bo, input logic [2:0] c, input logic [1:0] wl, input logic u);
        citd_exp_t x;
        x.d = '{g, op, bo, c, wl, u};
        x.aux = 16'h0000;
        return x;
    endfunction

    // store the word, wait for ready, offer it for one take and note the result
    task automatic issue(input logic [15:0] w, input logic [3:0] ev, input citd_exp_t e);
        int n;
        citd_exp_t x;
        n = 0;
        x = e;
        seed = lfsr(seed);
        wr_en = 1'b1;
        wr_addr = {seed[15:1], 1'b0};
        wr_data = w;
        @(posedge clk);
        #1;
        wr_en = 1'b0;
        while (ready !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        pc_value = wr_addr;
        operand_value = seed[31:16];
        if (e.d.group == citd_pkg::GRP_JUMP) begin
            x.aux = pc_value + {{5{w[9]}}, w[9:0], 1'b0};
        end else if (e.d.group == citd_pkg::GRP_SINGLE && e.d.op == 4'h1) begin
            x.aux = {operand_value[7:0], operand_value[15:8]};
        end
        {pin_rst, wd_rst, irq_accept, instr_valid} = ev;
        exp_q.push_back(x);
        @(posedge clk);
        #1;
        {pin_rst, wd_rst, irq_accept, instr_valid} = 4'h0;
    endtask

    // busy length and each done pulse against the oldest note, mid-cycle where outputs settle
    always @(negedge clk) begin : mon
        citd_exp_t e;
        if (busy === 1'b1) begin
            busy_n++;
        end
        if (done === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            `CHK(decode_out.group, e.d.group)
            `CHK(decode_out.cycles, e.d.cycles)
            `CHK(decode_out.words, e.d.words)
            `CHK(busy_n, int'(e.d.cycles))
            `CHK(ready, 1'b1)
            if (e.d.group < citd_pkg::GRP_IRQ || e.d.group == citd_pkg::GRP_ILLEGAL) begin
                `CHK(decode_out.op, e.d.op)
                `CHK(decode_out.undefined, e.d.undefined)
            end
            if (e.d.group == citd_pkg::GRP_DOUBLE || e.d.group == citd_pkg::GRP_SINGLE) begin
                `CHK(decode_out.byte_op, e.d.byte_op)
            end
            if (e.d.group == citd_pkg::GRP_JUMP) begin
                `CHK(jump_target, e.aux)
            end
            if (e.d.group == citd_pkg::GRP_SINGLE && e.d.op == 4'h1 && !e.d.undefined) begin
                `CHK(swap_result, e.aux)
            end
        end else if (done === 1'b1) begin
            `CHK(done, 1'b0)
        end
        if (done === 1'b1) begin
            busy_n = 0;
        end
    end

    // main sequence: events, singles, doubles, jumps
    initial begin
        logic [5:0] sm;
        logic [3:0] dn;
        logic [9:0] ofs;
        logic bo;
        int mm;
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        issue(16'h0000, 4'h2, mk(citd_pkg::GRP_IRQ, 4'h0, 1'b0, 3'h6, 2'h0, 1'b0));
        issue(16'h0000, 4'h4, mk(citd_pkg::GRP_WATCHDOG, 4'h0, 1'b0, 3'h4, 2'h0, 1'b0));
        issue(16'h0000, 4'h8, mk(citd_pkg::GRP_PIN, 4'h0, 1'b0, 3'h4, 2'h0, 1'b0));
        issue(16'h0000, 4'hC, mk(citd_pkg::GRP_PIN, 4'h0, 1'b0, 3'h4, 2'h0, 1'b0));
        issue(16'h4000, 4'h3, mk(citd_pkg::GRP_IRQ, 4'h0, 1'b0, 3'h6, 2'h0, 1'b0));
        issue(16'h1300, 4'h1, mk(citd_pkg::GRP_SINGLE, 4'h6, 1'b0, 3'h5, 2'h1, 1'b0));
        issue(16'h0123, 4'h1, mk(citd_pkg::GRP_ILLEGAL, 4'h0, 1'b0, 3'h1, 2'h1, 1'b1));
        for (int op = 0; op < 6; op++) begin
            for (int m = 0; m < 5; m++) begin
                seed = lfsr(seed);
                // shift-type words never carry an immediate destination
                mm = (op < 4 && m == 3) ? 4 : m;
                sm = mode_bits(mm, seed[3:0]);
                bo = seed[4] & ~op[0];
                issue({4'h1, 2'h0, 3'(op), bo, sm}, 4'h1, mk(citd_pkg::GRP_SINGLE, 4'(op), bo,
                    3'(SGL_CYC >> ((14 - ((op < 4 ? 0 : op - 3) * 5 + mm)) * 4)),
                    (mm < 3) ? 2'h1 : 2'h2, 1'b0));
            end
        end
        for (int opc = 4; opc < 16; opc++) begin
            for (int i = 0; i < 15; i++) begin
                seed = lfsr(seed);
                sm = mode_bits(i / 3, seed[3:0]);
                dn = (i % 3 == 1) ? 4'h0 : ((i % 3 == 0) ? {seed[7:5], 1'b1} : seed[7:4]);
                issue({4'(opc), sm[3:0], 1'(i % 3 == 2), seed[8], sm[5:4], dn}, 4'h1,
                    mk(citd_pkg::GRP_DOUBLE, 4'(opc), seed[8], 3'(DBL_CYC >> ((14 - i) * 4)),
                    2'(DBL_LEN >> ((14 - i) * 4)), 1'b0));
            end
        end
        for (int k = 0; k < 14; k++) begin
            seed = lfsr(seed);
            ofs = (k == 0) ? 10'h200 : ((k == 1) ? 10'h1FF : seed[9:0]);
            issue({3'h1, 3'(k % 7 + 1), ofs}, 4'h1,
                mk(citd_pkg::GRP_JUMP, 4'(k % 7 + 1), 1'b0, 3'h2, 2'h1, 1'b0));
        end
        repeat (12) @(posedge clk);
        `CHK(exp_q.size(), 0)
        end_of_test();
    end

    // counts, verdict and end of run
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
endmodule // test_cpu_instruction_timing_decode
`default_nettype wire
